// ===== logic/power_state_regs.vh
// Constants for the power-state controller: variants, states, timing
`ifndef POWER_STATE_REGS_VH
`define POWER_STATE_REGS_VH

// Variant codes
`define VAR_CORE_HI     3'h0
`define VAR_DVS_DDR     3'h1
`define VAR_LPDDR_500   3'h2
`define VAR_DVS_LPDDR   3'h3
`define VAR_BUCK4_OFF   3'h4

// One-hot power states
`define ST_OFF          5'h01
`define ST_HIBERNATE    5'h02
`define ST_LOWPOWER     5'h04
`define ST_ACTIVE       5'h08
`define ST_HIGHPERF     5'h10

// Rail vector bit positions
`define RAIL_BUCK1      0
`define RAIL_BUCK2      1
`define RAIL_BUCK3      2
`define RAIL_BUCK4      3
`define RAIL_LDO1       4
`define RAIL_LDO2       5
`define RAIL_W          6

// Reset values
`define RAILS_RESET     6'h00
`define MODE_RESET      4'h0

// Timing in microseconds; clock rate in MHz
`define DEBOUNCE_US     500
`define DEGLITCH_US     10
`define RESET_DELAY_US  16000
`define CLK_MHZ         250

// Cycle counts derived from the clock rate
`define DEBOUNCE_CYC    (`DEBOUNCE_US * `CLK_MHZ)
`define DEGLITCH_CYC    (`DEGLITCH_US * `CLK_MHZ)
`define RESET_DELAY_CYC (`RESET_DELAY_US * `CLK_MHZ)

// Voltage codes in millivolts
`define MV_3V3          16'h0CE4
`define MV_1V25         16'h04E2
`define MV_1V15         16'h047E
`define MV_1V8          16'h0708
`define MV_OFF          16'h0000

// Switching frequency
`define FSW_NOM_KHZ     2000
`define FSW_DISP_MAX    8'h21
`define FSW_DISP_MIN    8'hDF
`endif

// ===== logic/power_state_controller.v
// Power-state decoder, start debounce and reset release control
`timescale 1ns/10ps
`include "power_state_regs.vh"

module power_state_controller #(
    parameter [2:0]  VARIANT       = `VAR_DVS_LPDDR,
    parameter        DEBOUNCE_CYC  = `DEBOUNCE_CYC,
    parameter        DEGLITCH_CYC  = `DEGLITCH_CYC,
    parameter        RESET_DLY_CYC = `RESET_DELAY_CYC,
    parameter        PRESS_TO_CYC  = 32'h000F4240,
    parameter        WAKE_CYC      = 32'h0003D090
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Push-button start input and open-drain event output
    input  wire        pushbuttonStartIn,
    output wire        startEventOut,
    output wire        startEventOe_n,
    // Host mode inputs
    input  wire        powerHoldIn,
    input  wire        lowPowerRequestIn,
    input  wire        highPerfRequestIn,
    // Software control bits
    input  wire        highPerfUnmaskBit,
    input  wire        buck4SwEnable,
    input  wire        ldo2SwEnable,
    input  wire [7:0]  freqDisplacement,
    input  wire        autoWakeRequest,
    // Fault inputs
    input  wire        supplyUndervoltage,
    input  wire        systemFault,
    input  wire        buckOvercurrent,
    // Serial clock, never driven
    input  wire        serialClockIn,
    // Reset output, open drain
    output wire        systemResetOut,
    output wire        systemResetOe_n,
    // Rail controls
    output reg  [5:0]  railEnable_reg,
    output reg  [3:0]  forcedPwmSwitching_reg,
    output reg         buck4HighVoltage_reg,
    output reg  [7:0]  freqDisplacement_reg,
    output reg  [4:0]  powerState_reg,
    output reg         pushTimeout_reg,
    // Variant defaults in millivolts
    output reg  [15:0] buck1Mv_reg,
    output reg  [15:0] buck3Mv_reg,
    output reg  [15:0] buck4Mv_reg,
    output reg  [15:0] ldo2Mv_reg
);

    // ==============================================================
    // Synchronisers and filters
    reg  [3:0]  syncA_reg;
    reg  [3:0]  syncB_reg;
    reg  [2:0]  modeCand_reg;
    reg  [2:0]  modeStable_reg;
    reg  [31:0] glitchCnt_reg;
    reg  [31:0] debCnt_reg;
    reg         startValid_reg;

    wire        startLowNow = ~syncB_reg[3];
    // Mask applied before filtering so that unmasking is also filtered
    wire [2:0]  modeRaw = {syncB_reg[2],
                           syncB_reg[1],
                           syncB_reg[0] & highPerfUnmaskBit};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Button idles high, mode inputs idle low: no false request
            syncA_reg <= 4'h8;
            syncB_reg <= 4'h8;
        end else begin
            syncA_reg <= {pushbuttonStartIn, powerHoldIn,
                          lowPowerRequestIn, highPerfRequestIn};
            syncB_reg <= syncA_reg;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            modeCand_reg   <= 3'h0;
            modeStable_reg <= 3'h0;
            glitchCnt_reg  <= 32'h0;
        end else if (modeRaw != modeCand_reg) begin
            modeCand_reg  <= modeRaw;
            glitchCnt_reg <= 32'h0;
        end else if (glitchCnt_reg < DEGLITCH_CYC - 1) begin
            glitchCnt_reg <= glitchCnt_reg + 32'h1;
        end else begin
            modeStable_reg <= modeCand_reg;
        end
    end

    // Debounce: a press counts once low for the whole interval
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            debCnt_reg     <= 32'h0;
            startValid_reg <= 1'b0;
        end else begin
            if (!startLowNow) begin
                debCnt_reg     <= 32'h0;
                startValid_reg <= 1'b0;
            end else if (debCnt_reg < DEBOUNCE_CYC) begin
                debCnt_reg <= debCnt_reg + 32'h1;
            end else begin
                startValid_reg <= 1'b1;
            end
        end
    end

    // ==============================================================
    // Start event mirror and wake pulse
    reg  [31:0] wakeCnt_reg;
    wire        waking = (wakeCnt_reg != 32'h0);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            wakeCnt_reg <= 32'h0;
        else if (autoWakeRequest && !waking)
            wakeCnt_reg <= WAKE_CYC;
        else if (waking)
            wakeCnt_reg <= wakeCnt_reg - 32'h1;
    end

    // Mirror keeps following presses even while a sequence runs
    assign startEventOut  = 1'b0;
    assign startEventOe_n = ~(startLowNow | waking);

    // ==============================================================
    // Sequencer
    localparam SQ_IDLE  = 4'h1;
    localparam SQ_WAIT  = 4'h2;
    localparam SQ_RUN   = 4'h4;
    localparam SQ_DOWN  = 4'h8;

    reg  [3:0]  seq_reg;
    reg  [3:0]  seq_next;
    reg  [31:0] rstCnt_reg;
    reg  [31:0] pressCnt_reg;
    reg         resetRelease_reg;

    wire        holdHigh = modeStable_reg[2];
    wire        fault    = supplyUndervoltage | systemFault |
                           buckOvercurrent;
    wire        wakeStart = startValid_reg | waking;

    always @* begin
        seq_next = seq_reg;
        case (seq_reg)
            SQ_IDLE: begin
                if (wakeStart || holdHigh)
                    seq_next = SQ_WAIT;
            end
            // Start presses are not looked at here
            SQ_WAIT: begin
                if (rstCnt_reg >= RESET_DLY_CYC - 1)
                    seq_next = holdHigh ? SQ_RUN : SQ_DOWN;
            end
            SQ_RUN: begin
                if (!holdHigh || pushTimeout_reg)
                    seq_next = SQ_DOWN;
            end
            SQ_DOWN: begin
                if (!startLowNow)
                    seq_next = SQ_IDLE;
            end
            default: seq_next = SQ_IDLE;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_reg          <= SQ_IDLE;
            rstCnt_reg       <= 32'h0;
            pressCnt_reg     <= 32'h0;
            pushTimeout_reg  <= 1'b0;
            resetRelease_reg <= 1'b0;
        end else begin
            seq_reg <= seq_next;
            if (seq_reg == SQ_WAIT)
                rstCnt_reg <= rstCnt_reg + 32'h1;
            else
                rstCnt_reg <= 32'h0;
            // Run-time press only times out; otherwise no action
            if (seq_reg == SQ_RUN && startLowNow) begin
                if (pressCnt_reg < PRESS_TO_CYC)
                    pressCnt_reg <= pressCnt_reg + 32'h1;
                else
                    pushTimeout_reg <= 1'b1;
            end else begin
                pressCnt_reg    <= 32'h0;
                pushTimeout_reg <= 1'b0;
            end
            resetRelease_reg <= (seq_next == SQ_RUN);
        end
    end

    // ==============================================================
    // Power-state decoder
    reg  [4:0]  state_next;
    reg         running;

    always @* begin
        running    = (seq_reg == SQ_RUN) || (seq_reg == SQ_WAIT);
        state_next = powerState_reg;
        case (modeStable_reg)
            3'h0: state_next = `ST_OFF;
            3'h2: state_next = `ST_HIBERNATE;
            3'h6: state_next = `ST_LOWPOWER;
            3'h4: state_next = `ST_ACTIVE;
            3'h5: state_next = `ST_HIGHPERF;
            default: state_next = powerState_reg;
        endcase
        // Higher states are only reachable through the sequencer
        if (!running && state_next != `ST_HIBERNATE)
            state_next = `ST_OFF;
        // Hibernate survives a turn-off so its rails never blink off
        if (seq_reg == SQ_DOWN && state_next != `ST_HIBERNATE)
            state_next = `ST_OFF;
    end

    // Variant flags
    wire b4Excluded = (VARIANT == `VAR_CORE_HI) ||
                      (VARIANT == `VAR_BUCK4_OFF);
    wire b4Hibern   = (VARIANT == `VAR_LPDDR_500);
    wire ldo2Boot   = (VARIANT == `VAR_DVS_LPDDR);
    wire dvsVariant = (VARIANT == `VAR_DVS_DDR) ||
                      (VARIANT == `VAR_DVS_LPDDR);

    reg  [5:0]  rails_next;
    reg  [3:0]  pwm_next;

    always @* begin
        rails_next = `RAILS_RESET;
        pwm_next   = `MODE_RESET;
        case (powerState_reg)
            `ST_OFF: begin
                rails_next = `RAILS_RESET;
            end
            `ST_HIBERNATE: begin
                rails_next[`RAIL_BUCK2] = 1'b1;
                rails_next[`RAIL_BUCK4] = 1'b1;
            end
            `ST_LOWPOWER: begin
                rails_next = 6'h1F;
            end
            `ST_ACTIVE, `ST_HIGHPERF: begin
                rails_next = 6'h1F;
                pwm_next   = 4'hF;
            end
            default: rails_next = `RAILS_RESET;
        endcase
        if (powerState_reg != `ST_OFF) begin
            if (b4Excluded)
                rails_next[`RAIL_BUCK4] = buck4SwEnable &
                    (powerState_reg != `ST_HIBERNATE);
            if (b4Hibern && powerState_reg == `ST_HIBERNATE)
                rails_next[`RAIL_BUCK4] = 1'b1;
            if (powerState_reg != `ST_HIBERNATE)
                rails_next[`RAIL_LDO2] = ldo2Boot | ldo2SwEnable;
        end
    end

    // Displacement clamp keeps the switching rate within range
    wire        dispNeg  = freqDisplacement[7];
    wire [7:0]  dispClip = (!dispNeg && freqDisplacement > `FSW_DISP_MAX)
                           ? `FSW_DISP_MAX
                           : (dispNeg && freqDisplacement < `FSW_DISP_MIN)
                           ? `FSW_DISP_MIN : freqDisplacement;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powerState_reg         <= `ST_OFF;
            railEnable_reg         <= `RAILS_RESET;
            forcedPwmSwitching_reg <= `MODE_RESET;
            buck4HighVoltage_reg   <= 1'b0;
            freqDisplacement_reg   <= 8'h00;
        end else begin
            powerState_reg         <= state_next;
            railEnable_reg         <= rails_next;
            forcedPwmSwitching_reg <= pwm_next;
            buck4HighVoltage_reg   <= dvsVariant &&
                                      (powerState_reg == `ST_HIGHPERF);
            freqDisplacement_reg   <= dispClip;
        end
    end

    // Variant voltage defaults taken once after reset release
    reg loaded_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loaded_reg  <= 1'b0;
            buck1Mv_reg <= `MV_OFF;
            buck3Mv_reg <= `MV_OFF;
            buck4Mv_reg <= `MV_OFF;
            ldo2Mv_reg  <= `MV_OFF;
        end else if (!loaded_reg) begin
            loaded_reg  <= 1'b1;
            buck1Mv_reg <= `MV_3V3;
            buck3Mv_reg <= (VARIANT == `VAR_CORE_HI ||
                            VARIANT == `VAR_LPDDR_500)
                           ? `MV_1V25 : `MV_1V15;
            buck4Mv_reg <= b4Excluded ? `MV_OFF :
                           b4Hibern ? `MV_1V8 : `MV_1V15;
            ldo2Mv_reg  <= ldo2Boot ? `MV_1V8 : `MV_OFF;
        end
    end

    // ==============================================================
    // Reset output: fault or hibernate pulls low at once
    wire resetLow = fault || !resetRelease_reg ||
                    (powerState_reg == `ST_HIBERNATE) ||
                    (powerState_reg == `ST_OFF);
    assign systemResetOut  = 1'b0;
    assign systemResetOe_n = ~resetLow;

endmodule // power_state_controller

// ===== verification/power_state_checker_assertions.sv
// Port-level assertions for the power-state controller
`timescale 1ns/10ps
`include "power_state_regs.vh"
// ==========
// Checker
module power_state_checker (
    // Clock and reset
    input wire       clk,
    input wire       rst_n,
    // Inputs
    input wire       pushbuttonStartIn,
    input wire       powerHoldIn,
    input wire       lowPowerRequestIn,
    input wire       highPerfRequestIn,
    input wire       highPerfUnmaskBit,
    input wire       supplyUndervoltage,
    input wire       systemFault,
    input wire       buckOvercurrent,
    // Outputs
    input wire       startEventOe_n,
    input wire       systemResetOe_n,
    input wire [5:0] railEnable_reg,
    input wire [3:0] forcedPwmSwitching_reg,
    input wire [4:0] powerState_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Rails lag the state by an edge, so only settled states are judged
    a_off_rails: assert property (
        $stable(powerState_reg) && powerState_reg == `ST_OFF
        |-> railEnable_reg == `RAILS_RESET) else $error("rails on in off");
    a_hib_rails: assert property (
        $stable(powerState_reg) && powerState_reg == `ST_HIBERNATE
        |-> (railEnable_reg & 6'h37) == 6'h02
        && forcedPwmSwitching_reg[1] == 1'b0) else $error("bad hib rails");
    a_lp_rails: assert property (
        $stable(powerState_reg) && powerState_reg == `ST_LOWPOWER
        |-> (railEnable_reg & 6'h17) == 6'h17
        && forcedPwmSwitching_reg[2:0] == 3'h0) else $error("bad lp rails");
    a_run_pwm: assert property (
        $stable(powerState_reg) && (powerState_reg == `ST_ACTIVE
        || powerState_reg == `ST_HIGHPERF)
        |-> (railEnable_reg & 6'h17) == 6'h17
        && forcedPwmSwitching_reg[2:0] == 3'h7) else $error("bad run rails");
    a_low_reset: assert property (
        powerState_reg == `ST_OFF || powerState_reg == `ST_HIBERNATE
        |-> systemResetOe_n == 1'b0) else $error("reset released");
    a_fault_reset: assert property (
        supplyUndervoltage || systemFault || buckOvercurrent
        |-> systemResetOe_n == 1'b0) else $error("fault kept reset off");
    a_start_mirror: assert property (
        !pushbuttonStartIn [*3] |-> startEventOe_n == 1'b0)
        else $error("start press not mirrored");
    a_hp_masked: assert property (
        !highPerfUnmaskBit [*8] |-> powerState_reg != `ST_HIGHPERF)
        else $error("masked high-perf entered");
    a_forbid_hold: assert property (
        (powerHoldIn && lowPowerRequestIn && highPerfRequestIn
        && highPerfUnmaskBit) [*8]
        |-> $stable(powerState_reg) && $stable(railEnable_reg))
        else $error("forbidden combo changed state");
endmodule // power_state_checker

bind power_state_controller power_state_checker u_chk (
    .clk, .rst_n, .pushbuttonStartIn, .powerHoldIn, .lowPowerRequestIn,
    .highPerfRequestIn, .highPerfUnmaskBit, .supplyUndervoltage,
    .systemFault, .buckOvercurrent, .startEventOe_n, .systemResetOe_n,
    .railEnable_reg, .forcedPwmSwitching_reg, .powerState_reg);

// ===== verification/host_cpu_model.sv
// Host processor model: mode pins and start button
`timescale 1ns/10ps
// ==========
// Host model
module host_cpu_model (
    // Clock
    input  wire       clk,
    // Bench commands
    input  wire [2:0] modeSel,
    input  wire [7:0] pressLen,
    // Pins: hold, low-power, high-perf; button low when pressed
    output reg  [2:0] modePins,
    output wire       button
);
    reg [7:0] pressCnt_reg;
    initial modePins = 3'h0;
    initial pressCnt_reg = 8'h00;
    always @(negedge clk) begin
        case (modeSel)
            3'h1: modePins <= 3'h2;
            3'h2: modePins <= 3'h6;
            3'h3: modePins <= 3'h4;
            3'h4: modePins <= 3'h5;
            3'h7: modePins <= 3'h7; // Misuse only on bench request
            default: modePins <= 3'h0;
        endcase
        // Every press is released after a bounded time
        if (pressLen != 8'h00) begin
            pressCnt_reg <= pressLen;
        end else if (pressCnt_reg != 8'h00) begin
            pressCnt_reg <= pressCnt_reg - 8'h01;
        end
    end
    assign button = (pressCnt_reg == 8'h00);
endmodule // host_cpu_model

// ===== verification/power_state_controller_tb_top.sv
// Self-checking bench for the power-state controller
`timescale 1ns/10ps
`include "power_state_regs.vh"
// ==========
// Bench top
module power_state_controller_tb_top;
    reg         clk;
    reg         rst_n;
    reg  [2:0]  modeSel;
    reg  [7:0]  pressLen;
    reg         unmask;
    reg  [7:0]  freqIn;
    reg  [2:0]  faults;
    reg         tieLow;
    reg         wakeReq;
    reg         ldo2En;
    wire        sOut;
    wire        rOut;
    wire        b4Hi;
    wire [2:0]  pins;
    wire        button;
    wire        startOe_n;
    wire        rstOe_n;
    wire [5:0]  rails;
    wire [3:0]  pwm;
    wire        pushTo;
    wire [7:0]  freqOut;
    wire [4:0]  state;
    wire [15:0] mv1, mv3, mv4, mvL2;
    integer     n_errors;
    integer     comparisons;
    integer     i;

    host_cpu_model host (.clk(clk), .modeSel(modeSel), .pressLen(pressLen),
        .modePins(pins), .button(button));
    power_state_controller #(.VARIANT(`VAR_LPDDR_500), .DEBOUNCE_CYC(8),
        .DEGLITCH_CYC(4), .RESET_DLY_CYC(20), .PRESS_TO_CYC(50),
        .WAKE_CYC(10)) dut (
        .clk(clk), .rst_n(rst_n), .pushbuttonStartIn(button),
        .startEventOut(sOut), .startEventOe_n(startOe_n),
        .powerHoldIn(pins[2]), .lowPowerRequestIn(pins[1]),
        .highPerfRequestIn(pins[0]), .highPerfUnmaskBit(unmask),
        .buck4SwEnable(tieLow), .ldo2SwEnable(ldo2En),
        .freqDisplacement(freqIn), .autoWakeRequest(wakeReq),
        .supplyUndervoltage(faults[2]), .systemFault(faults[1]),
        .buckOvercurrent(faults[0]), .serialClockIn(tieLow),
        .systemResetOut(rOut), .systemResetOe_n(rstOe_n),
        .railEnable_reg(rails), .forcedPwmSwitching_reg(pwm),
        .buck4HighVoltage_reg(b4Hi), .freqDisplacement_reg(freqOut),
        .powerState_reg(state), .pushTimeout_reg(pushTo),
        .buck1Mv_reg(mv1), .buck3Mv_reg(mv3), .buck4Mv_reg(mv4),
        .ldo2Mv_reg(mvL2));

    always #2 clk = ~clk;

    task cyc(input integer n);
        begin
            repeat (n) @(negedge clk);
        end
    endtask
    task check(input [63:0] what, input [15:0] exp, input [15:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task press(input [7:0] len);
        begin
            pressLen <= len;
            cyc(1);
            pressLen <= 8'h00;
        end
    endtask
    // Bounded wait: reset release trails the state by the sequencer delay
    task goMode(input [2:0] sel, input [4:0] st, input [5:0] rl,
        input [3:0] pw, input rs);
        integer k;
        begin
            modeSel <= sel;
            k = 0;
            while (k < 40 && (state !== st || rstOe_n !== rs)) begin
                cyc(1);
                k = k + 1;
            end
            cyc(2);
            check("state", st, state);
            check("rails", rl, rails);
            check("pwm", pw, pwm);
            check("resetOe", rs, rstOe_n);
        end
    endtask
    task freqStep(input [7:0] v, input [7:0] e);
        begin
            freqIn <= v;
            cyc(3);
            check("freq", e, freqOut);
        end
    endtask
    task stop_test;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_errors);
            if (n_errors == 0 && comparisons > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    initial begin
        #20000;
        n_errors = n_errors + 1;
        $display("[FAIL] watchdog expected end seen hang");
        stop_test;
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        modeSel = 3'h0;
        pressLen = 8'h00;
        unmask = 1'b0;
        freqIn = 8'h00;
        faults = 3'h0;
        tieLow = 1'b0;
        wakeReq = 1'b0;
        ldo2En = 1'b0;
        n_errors = 0;
        comparisons = 0;
        cyc(12);
        rst_n <= 1'b1;
        cyc(2);
        check("state", `ST_OFF, state);
        check("rails", `RAILS_RESET, rails);
        check("resetOe", 1'b0, rstOe_n);
        check("startOe", 1'b1, startOe_n);
        check("buck1Mv", `MV_3V3, mv1);
        check("buck3Mv", `MV_1V25, mv3);
        check("buck4Mv", `MV_1V8, mv4);
        check("ldo2Mv", `MV_OFF, mvL2);
        check("startOut", 1'b0, sOut);
        check("rstOut", 1'b0, rOut);
        $display("power-on test done");
        goMode(3'h1, `ST_HIBERNATE, 6'h0A, 4'h0, 1'b0);
        goMode(3'h0, `ST_OFF, 6'h00, 4'h0, 1'b0);
        $display("hibernate test done");
        press(8'd14);
        cyc(3);
        check("startOe", 1'b0, startOe_n);
        cyc(40);
        check("startOe", 1'b1, startOe_n);
        check("state", `ST_OFF, state);
        check("resetOe", 1'b0, rstOe_n);
        $display("unheld press test done");
        press(8'd14);
        cyc(12);
        modeSel <= 3'h3;
        cyc(10);
        check("resetOe", 1'b0, rstOe_n);
        goMode(3'h3, `ST_ACTIVE, 6'h1F, 4'hF, 1'b1);
        goMode(3'h2, `ST_LOWPOWER, 6'h1F, 4'h0, 1'b1);
        goMode(3'h4, `ST_ACTIVE, 6'h1F, 4'hF, 1'b1);
        unmask <= 1'b1;
        goMode(3'h4, `ST_HIGHPERF, 6'h1F, 4'hF, 1'b1);
        check("b4HiV", 1'b0, b4Hi);
        modeSel <= 3'h7;
        cyc(20);
        check("state", `ST_HIGHPERF, state);
        check("rails", 6'h1F, rails);
        modeSel <= 3'h4;
        $display("power-up test done");
        for (i = 0; i < 3; i = i + 1) begin
            faults <= {i == 2, i == 1, i == 0};
            cyc(1);
            check("resetOe", 1'b0, rstOe_n);
            faults <= 3'h0;
            goMode(3'h4, `ST_HIGHPERF, 6'h1F, 4'hF, 1'b1);
        end
        $display("fault test done");
        freqStep(8'h10, 8'h10);
        freqStep(8'h7F, `FSW_DISP_MAX);
        freqStep(8'hDF, `FSW_DISP_MIN);
        freqStep(8'h80, `FSW_DISP_MIN);
        $display("frequency test done");
        ldo2En <= 1'b1;
        cyc(2);
        check("rails", 6'h3F, rails);
        ldo2En <= 1'b0;
        press(8'd20);
        cyc(24);
        check("state", `ST_HIGHPERF, state);
        check("pushTo", 1'b0, pushTo);
        press(8'h46);
        // The timeout flag clears one edge after the sequencer leaves run, while the press is still held
        i = 0;
        while (i < 64 && pushTo !== 1'b1) begin
            cyc(1);
            i = i + 1;
        end
        check("pushTo", 1'b1, pushTo);
        check("pushWait", 1'b1, i >= 50);
        cyc(10);
        goMode(3'h1, `ST_HIBERNATE, 6'h0A, 4'h0, 1'b0);
        $display("run-time press test done");
        wakeReq <= 1'b1;
        cyc(1);
        wakeReq <= 1'b0;
        cyc(3);
        check("startOe", 1'b0, startOe_n);
        cyc(12);
        check("startOe", 1'b1, startOe_n);
        $display("wake pulse test done");
        rst_n <= 1'b0;
        cyc(2);
        check("state", `ST_OFF, state);
        check("rails", `RAILS_RESET, rails);
        check("resetOe", 1'b0, rstOe_n);
        rst_n <= 1'b1;
        cyc(2);
        check("state", `ST_OFF, state);
        check("buck1Mv", `MV_3V3, mv1);
        $display("mid-run reset test done");
        stop_test;
    end
endmodule // power_state_controller_tb_top
